// *** src/ncm_consts.svh ***
// Purpose: Offsets, field positions, reset values for the node config and map block
// Assumes: Included by bare name; definitions only
// Notes:   Byte offsets in node CSR space
`ifndef NCM_CONSTS_SVH
`define NCM_CONSTS_SVH

`define NCM_CSR_AW          12
`define NCM_OFF_CFG         12'h080
`define NCM_OFF_MAP_FIRST   12'h200
`define NCM_OFF_MAP_LAST    12'h3c0
`define NCM_MAP_IDX_LSB     6
`define NCM_MAP_IDX_W       3

`define NCM_CFG_STF_BIT     31
`define NCM_CFG_NODE_RESET_REQUEST_BIT    30
`define NCM_CFG_HALT_BIT    29
`define NCM_CFG_JOIN_BIT    28
`define NCM_CFG_CORR_ERR_DETECT_ENABLE_BIT    0

`define NCM_CFG_STF_RST     1'b1
`define NCM_CFG_HALT_RST    1'b0
`define NCM_CFG_JOIN_RST    1'b0
`define NCM_CFG_CORR_ERR_DETECT_ENABLE_RST    1'b0
`define NCM_MAP_RST         32'h0000_0000

`define NCM_MADDR_W         40
`define NCM_MADDR_BASE_LSB  25
`define NCM_BASE_W          15
`define NCM_ILV_LSB         6
`define NCM_ILV_RSVD        2'h3

`endif

// *** src/ncm_pkg.sv ***
// Purpose: Types shared by the node config and map block
// Assumes: Nothing beyond the consts header
// Notes:   Field layout of a map entry follows its bit positions
package ncm_pkg;

  // One memory map entry, bit 31 down to bit 0
  typedef struct packed {
    logic [14:0] baseAddr;     // Byte address bits 39:25
    logic [5:0]  zeroFill;     // Always zero
    logic [1:0]  bankCode;     // Banks 1, 2, 4, 8
    logic [3:0]  widthCode;    // Valid base bits from the top
    logic [1:0]  slot;         // Interleave position
    logic [1:0]  ilvCode;      // Interleave 1, 2, 4
    logic        present;      // Installed memory module
  } ncm_map_entry_t;

  // Stored configuration bits
  typedef struct packed {
    logic selfTestPending;
    logic haltReq;
    logic resetJoin;
    logic corrErrDetectEn;
  } ncm_cfg_t;

endpackage

// *** src/ncm_cfg_reg.sv ***
// Purpose: Node configuration and status bits
// Assumes: Full 32-bit writes only
// Notes:   Node reset request is a one-cycle pulse, never stored
`include "ncm_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ncm_cfg_reg (
  input  wire logic              clk,            // Clock
  input  wire logic              arst_n,         // Async reset, active low
  input  wire logic              cfgWr,          // Write strobe for this register
  input  wire logic [31:0]       wrData,         // Write data
  input  wire logic              busResetCmd,    // Bus-wide reset command pulse
  output var  ncm_pkg::ncm_cfg_t cfg,            // Stored bits
  output logic                   nodeResetPulse  // Start of node reset sequence
);

  logic joinSet;
  logic joinClr;
  logic stfClr;

  // Write strobes decoded from the write word
  assign joinSet = cfgWr & wrData[`NCM_CFG_NODE_RESET_REQUEST_BIT];
  assign joinClr = (cfgWr & wrData[`NCM_CFG_JOIN_BIT]) | busResetCmd;
  assign stfClr  = cfgWr & wrData[`NCM_CFG_STF_BIT];

  // Stored bits; join flag set wins over clear, node reset leaves it alone
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg.selfTestPending <= `NCM_CFG_STF_RST;
      cfg.haltReq         <= `NCM_CFG_HALT_RST;
      cfg.resetJoin       <= `NCM_CFG_JOIN_RST;
      cfg.corrErrDetectEn <= `NCM_CFG_CORR_ERR_DETECT_ENABLE_RST;
      nodeResetPulse      <= 1'b0;
    end else begin
      cfg.selfTestPending <= cfg.selfTestPending & ~stfClr;
      cfg.haltReq         <= cfgWr ? wrData[`NCM_CFG_HALT_BIT] : cfg.haltReq;
      cfg.resetJoin       <= joinSet | (cfg.resetJoin & ~joinClr);
      cfg.corrErrDetectEn <= cfgWr ? wrData[`NCM_CFG_CORR_ERR_DETECT_ENABLE_BIT] : cfg.corrErrDetectEn;
      nodeResetPulse      <= joinSet;
    end
  end
endmodule
`default_nettype wire

// *** src/ncm_addr_match.sv ***
// Purpose: Decide whether a memory address belongs to one map entry
// Assumes: Entry holds a copy of the module's own map register
// Notes:   Reserved interleave code never hits
`include "ncm_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ncm_addr_match (
  input  wire ncm_pkg::ncm_map_entry_t      entry,    // Map entry
  input  wire logic [`NCM_MADDR_W-1:0]      addr,     // Byte address
  output logic                              hit,      // Address in this module
  output logic [2:0]                        bankNum   // Bank number bits
);

  // Top widthCode bits of the base are compared
  function automatic logic [`NCM_BASE_W-1:0] base_mask(input logic [3:0] w);
    base_mask = ~(15'h7fff >> w);
  endfunction

  // Low n bits set, n from a two-bit code
  function automatic logic [2:0] low_mask(input logic [1:0] c);
    low_mask = 3'h7 >> (2'h3 - c);
  endfunction

  wire logic [`NCM_BASE_W-1:0] addrBase = addr[`NCM_MADDR_BASE_LSB +: `NCM_BASE_W];
  wire logic [`NCM_BASE_W-1:0] bMask    = base_mask(entry.widthCode);
  wire logic [2:0]             ilvFull  = low_mask(entry.ilvCode);
  wire logic [1:0]             ilvMask  = ilvFull[1:0];
  wire logic [1:0]             ilvBits  = addr[`NCM_ILV_LSB +: 2];
  wire logic [1:0]             ilvShift = (entry.ilvCode == 2'h0) ? 2'h0 : entry.ilvCode;
  wire logic [`NCM_MADDR_W-1:0] above   = addr >> (`NCM_ILV_LSB + ilvShift);
  wire logic                   baseOk   = ((addrBase ^ entry.baseAddr) & bMask) == 15'h0000;
  wire logic                   slotOk   = (entry.ilvCode == 2'h0) ||
                                          (((ilvBits ^ entry.slot) & ilvMask) == 2'h0);

  // Match needs present, base and slot
  assign hit     = entry.present && baseOk && slotOk && (entry.ilvCode != `NCM_ILV_RSVD);
  // Bank bits taken above the interleave bits
  assign bankNum = above[2:0] & (3'h7 >> (2'h3 - entry.bankCode));

endmodule
`default_nettype wire

// *** src/ncm_node_config_and_memory_map.sv ***
// Purpose: Node configuration register and eight memory map registers
// Assumes: CSR accesses are full 32-bit words on the documented port
// Notes:   Lookups return one cycle after the request
// How it works
// - Self-test pending resets to one, software clears it by writing one.
// - Writing one to node reset bit enters console mode, starts reset.
// - Halt request bit forces console mode while set; resets to zero.
// - Reset-join flag sets whenever the node reset bit is written one.
// - Reset-join clears by write one, power-up or bus reset command.
// - Reset-join flag survives the node reset sequence it triggered.
// - Correctable error detection active only while bit 0 is one.
// - Eight map registers at 0x200..0x3c0, node is index low bits.
// - Map bits 31:17 hold base address bits 39:25.
// - Map bits 16:11 read zero and ignore writes.
// - Bank code 0..3 means 1,2,4,8 banks and 0..3 bank bits.
// - Width code says how many top base bits are matched.
// - Slot field names the interleave position the module serves.
// - Interleave code 0..2 means 1,2,4 modules; code 3 reserved.
// - Writes to read-only bits are acknowledged with no effect.
`include "ncm_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ncm_node_config_and_memory_map #(
  parameter int NODES = 8                               // Map entries
) (
  input  wire logic                     clk,             // Clock, 100 MHz
  input  wire logic                     arst_n,          // Async reset, active low
  input  wire logic [`NCM_CSR_AW-1:0]   csrAddr,         // CSR byte offset
  input  wire logic                     csrRd,           // Read request
  input  wire logic                     csrWr,           // Write request
  input  wire logic [31:0]              csrWrData,       // Write data
  output logic      [31:0]              csrRdData,       // Read data
  output logic                          csrAck,          // Access done pulse
  input  wire logic                     busResetCmd,     // Bus reset command pulse
  input  wire logic                     lookupValid,     // Address lookup request
  input  wire logic [`NCM_MADDR_W-1:0]  lookupAddr,      // Address to decode
  output logic                          lookupDone,      // Lookup answer pulse
  output logic                          lookupHit,       // Some node owns address
  output logic      [2:0]               lookupNode,      // Owning node
  output logic      [2:0]               lookupBank,      // Bank number
  output logic      [NODES-1:0]         nodePresent,     // Present bits of entries
  output logic                          consoleMode,     // Node in console mode
  output logic                          nodeResetStart,  // Node reset sequence start
  output logic                          selfTestPending, // Self-test not done
  output logic                          corrErrDetectEn, // Correctable error enable
  output logic                          resetJoin        // Join running system
);

  // Map storage
  ncm_pkg::ncm_map_entry_t mapReg [NODES];
  ncm_pkg::ncm_cfg_t       cfg;
  logic                    nrstPulse;

  // Address decode
  wire logic                         cfgSel  = (csrAddr == `NCM_OFF_CFG);
  wire logic                         mapSel  = (csrAddr >= `NCM_OFF_MAP_FIRST) &&
                                               (csrAddr <= `NCM_OFF_MAP_LAST) &&
                                               (csrAddr[`NCM_MAP_IDX_LSB-1:0] == 6'h00);
  wire logic [`NCM_MAP_IDX_W-1:0]    mapIdx  = csrAddr[`NCM_MAP_IDX_LSB +: `NCM_MAP_IDX_W];
  wire logic                         cfgWr   = csrWr && cfgSel;
  wire logic                         mapWr   = csrWr && mapSel;

  // Configuration bits
  ncm_cfg_reg u_cfg (
    .clk            (clk),
    .arst_n         (arst_n),
    .cfgWr          (cfgWr),
    .wrData         (csrWrData),
    .busResetCmd    (busResetCmd),
    .cfg            (cfg),
    .nodeResetPulse (nrstPulse)
  );

  // Write data cleaned of reserved bits
  function automatic ncm_pkg::ncm_map_entry_t map_clean(input logic [31:0] d);
    ncm_pkg::ncm_map_entry_t e;
    e          = d;
    e.zeroFill = 6'h00;
    return e;
  endfunction

  // Map registers, loaded by init software
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NODES; i++) begin
        mapReg[i] <= `NCM_MAP_RST;
      end
    end else if (mapWr) begin
      mapReg[mapIdx] <= map_clean(csrWrData);
    end
  end

  // Configuration read image; reset request reads zero
  wire logic [31:0] cfgImage = {cfg.selfTestPending, 1'b0, cfg.haltReq, cfg.resetJoin,
                                27'h0000000, cfg.corrErrDetectEn};
  // Read mux; unmapped offsets read zero
  wire logic [31:0] rdMux = cfgSel ? cfgImage :
                            mapSel ? 32'(mapReg[mapIdx]) : 32'h0000_0000;

  // Bus answer, one cycle after request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      csrAck    <= 1'b0;
      csrRdData <= 32'h0000_0000;
    end else begin
      csrAck    <= csrRd || csrWr;
      csrRdData <= csrRd ? rdMux : 32'h0000_0000;
    end
  end

  // Per-entry address match
  logic [NODES-1:0] hitVec;
  logic [2:0]       bankVec [NODES];
  for (genvar g = 0; g < NODES; g++) begin : g_match
    ncm_addr_match u_match (
      .entry   (mapReg[g]),
      .addr    (lookupAddr),
      .hit     (hitVec[g]),
      .bankNum (bankVec[g])
    );
  end

  // Lowest numbered hit wins; slot per entry
  logic [2:0] firstNode;
  logic       anyHit;
  always_comb begin
    firstNode = 3'h0;
    anyHit    = 1'b0;
    for (int i = NODES - 1; i >= 0; i--) begin
      if (hitVec[i]) begin
        firstNode = 3'(i);
        anyHit    = 1'b1;
      end
    end
  end

  // Lookup answer registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lookupDone <= 1'b0;
      lookupHit  <= 1'b0;
      lookupNode <= 3'h0;
      lookupBank <= 3'h0;
    end else begin
      lookupDone <= lookupValid;
      lookupHit  <= lookupValid && anyHit;
      lookupNode <= firstNode;
      lookupBank <= anyHit ? bankVec[firstNode] : 3'h0;
    end
  end

  // Present bits of all entries
  logic [NODES-1:0] presentNow;
  always_comb begin
    for (int i = 0; i < NODES; i++) begin
      presentNow[i] = mapReg[i].present;
    end
  end

  // Status outputs straight from flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nodePresent     <= '0;
      consoleMode     <= 1'b0;
      nodeResetStart  <= 1'b0;
      selfTestPending <= `NCM_CFG_STF_RST;
      corrErrDetectEn <= `NCM_CFG_CORR_ERR_DETECT_ENABLE_RST;
      resetJoin       <= `NCM_CFG_JOIN_RST;
    end else begin
      nodePresent     <= presentNow;
      consoleMode     <= cfg.haltReq || nrstPulse;
      nodeResetStart  <= nrstPulse;
      selfTestPending <= cfg.selfTestPending;
      corrErrDetectEn <= cfg.corrErrDetectEn;
      resetJoin       <= cfg.resetJoin;
    end
  end

endmodule
`default_nettype wire

// *** tb/ncm_props.sv ***
// Purpose: Timing checks on the node config and map block ports
// Assumes: Bound to the top module, one clock domain
// Notes:   Config outputs lag the register by one cycle
`include "ncm_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module ncm_props (
  input wire logic                   clk,            // Clock
  input wire logic                   arst_n,         // Async reset, active low
  input wire logic [`NCM_CSR_AW-1:0] csrAddr,        // Offset
  input wire logic                   csrRd,          // Read request
  input wire logic                   csrWr,          // Write request
  input wire logic [31:0]            csrWrData,      // Write data
  input wire logic [31:0]            csrRdData,      // Read data
  input wire logic                   csrAck,         // Access done
  input wire logic                   busResetCmd,    // Bus reset command
  input wire logic                   lookupValid,    // Lookup request
  input wire logic                   lookupDone,     // Lookup answer
  input wire logic                   consoleMode,    // Console mode
  input wire logic                   nodeResetStart, // Node reset start
  input wire logic                   resetJoin       // Join flag
);
  // Node reset request write
  wire logic nrstWr = csrWr && (csrAddr == 12'h080) && csrWrData[30];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Bus and lookup answers
  ack_timing_a: assert property ((csrRd || csrWr) |=> csrAck)
    else $error("Access not acknowledged");
  idle_data_a: assert property (!csrAck |-> csrRdData == 32'h0)
    else $error("Read data without ack");
  node_reset_request_read_a: assert property (csrAck && $past(csrRd) && $past(csrAddr) == 12'h080
    |-> csrRdData[30] == 1'b0 && csrRdData[27:1] == 27'h0) else $error("Bad config read");
  rsvd_read_a: assert property (csrAck && $past(csrRd) && $past(csrAddr) >= 12'h200
    |-> csrRdData[16:11] == 6'h0) else $error("Reserved map bits not zero");
  lookup_done_a: assert property (lookupValid |=> lookupDone)
    else $error("Lookup not answered");
  // Node reset and join flag
  reset_start_a: assert property (nrstWr |=> ##1 nodeResetStart)
    else $error("Node reset not started");
  join_set_a: assert property (nrstWr |=> ##1 resetJoin)
    else $error("Join flag not set");
  console_on_a: assert property (nodeResetStart |-> consoleMode)
    else $error("Node reset without console mode");
  join_clear_a: assert property (busResetCmd && !nrstWr |=> ##1 !resetJoin)
    else $error("Join flag not cleared");
endmodule

bind ncm_node_config_and_memory_map ncm_props ncm_props_i (.clk(clk), .arst_n(arst_n),
  .csrAddr(csrAddr), .csrRd(csrRd), .csrWr(csrWr), .csrWrData(csrWrData),
  .csrRdData(csrRdData), .csrAck(csrAck), .busResetCmd(busResetCmd),
  .lookupValid(lookupValid), .lookupDone(lookupDone), .consoleMode(consoleMode),
  .nodeResetStart(nodeResetStart), .resetJoin(resetJoin));
`default_nettype wire

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the node config and map block
// Assumes: Inputs driven 1 ns after the rising edge
// Notes:   Expectations come from the register layout
`include "ncm_consts.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin err_count++; \
  $display("FAIL %s exp %h got %h", nm, ex, gt); end end

module tb_top;
  logic        clk, arst_n, csrRd, csrWr, csrAck, busResetCmd;
  logic        lookupValid, lookupDone, lookupHit, consoleMode;
  logic        nodeResetStart, selfTestPending, corrErrDetectEn, resetJoin;
  logic [11:0] csrAddr;
  logic [31:0] csrWrData, csrRdData;
  logic [39:0] lookupAddr;
  logic [2:0]  lookupNode, lookupBank;
  logic [7:0]  nodePresent;
  int          err_count = 0, cmp_count = 0, cyc = 0;

  ncm_node_config_and_memory_map ncm_node_config_and_memory_map_i (.clk(clk),
    .arst_n(arst_n), .csrAddr(csrAddr), .csrRd(csrRd), .csrWr(csrWr), .csrWrData(csrWrData),
    .csrRdData(csrRdData), .csrAck(csrAck), .busResetCmd(busResetCmd),
    .lookupValid(lookupValid), .lookupAddr(lookupAddr), .lookupDone(lookupDone),
    .lookupHit(lookupHit), .lookupNode(lookupNode), .lookupBank(lookupBank),
    .nodePresent(nodePresent), .consoleMode(consoleMode), .nodeResetStart(nodeResetStart),
    .selfTestPending(selfTestPending), .corrErrDetectEn(corrErrDetectEn),
    .resetJoin(resetJoin));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  // Register write, then one idle cycle
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    csrAddr = a;
    csrWrData = d;
    csrWr = 1'b1;
    step();
    `CHK("wack", 1'b1, csrAck)
    csrWr = 1'b0;
    step();
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    csrAddr = a;
    csrRd = 1'b1;
    step();
    `CHK("rack", 1'b1, csrAck)
    `CHK("rdata", e, csrRdData)
    csrRd = 1'b0;
    step();
  endtask
  task automatic lk(input logic [39:0] a, input logic h, input logic [2:0] nd, bk);
    lookupAddr = a;
    lookupValid = 1'b1;
    step();
    lookupValid = 1'b0;
    `CHK("done", 1'b1, lookupDone)
    `CHK("hit", h, lookupHit)
    if (h) begin
      `CHK("node", nd, lookupNode)
      `CHK("bank", bk, lookupBank)
    end
    step();
  endtask

  task automatic t_reset();
    `CHK("stp", 1'b1, selfTestPending)
    `CHK("corr_err_detect_enable", 1'b0, corrErrDetectEn)
    `CHK("join", 1'b0, resetJoin)
    `CHK("cons", 1'b0, consoleMode)
    rd(12'h080, 32'h8000_0000);
    for (int n = 0; n < 8; n++) rd(12'h200 + 12'(n * 64), 32'h0);
    $display("test reset done");
  endtask
  task automatic t_cfg();
    wr(12'h080, 32'h2000_0001);
    `CHK("cons", 1'b1, consoleMode)
    `CHK("corr_err_detect_enable", 1'b1, corrErrDetectEn)
    rd(12'h080, 32'ha000_0001);
    wr(12'h080, 32'h8000_0001);
    rd(12'h080, 32'h0000_0001);
    `CHK("stp", 1'b0, selfTestPending)
    `CHK("cons", 1'b0, consoleMode)
    $display("test cfg done");
  endtask
  task automatic t_node_reset_request();
    wr(12'h080, 32'h4000_0000);
    `CHK("nrs", 1'b1, nodeResetStart)
    `CHK("join", 1'b1, resetJoin)
    `CHK("corr_err_detect_enable", 1'b0, corrErrDetectEn)
    rd(12'h080, 32'h1000_0000);
    `CHK("nrs", 1'b0, nodeResetStart)
    `CHK("join", 1'b1, resetJoin)
    wr(12'h080, 32'h1000_0000);
    `CHK("join", 1'b0, resetJoin)
    wr(12'h080, 32'h5000_0000);
    `CHK("join", 1'b1, resetJoin)
    busResetCmd = 1'b1;
    step();
    busResetCmd = 1'b0;
    step();
    `CHK("join", 1'b0, resetJoin)
    $display("test node_reset_request done");
  endtask
  task automatic t_map();
    logic [31:0] d;
    for (int n = 0; n < 8; n++) begin
      d = {4'(n), 27'h7ff_ffff, 1'(n)};
      wr(12'h200 + 12'(n * 64), d);
      rd(12'h200 + 12'(n * 64), d & 32'hfffe_07ff);
    end
    `CHK("pres", 8'haa, nodePresent)
    wr(12'h100, 32'hffff_ffff);
    rd(12'h100, 32'h0);
    $display("test map done");
  endtask
  task automatic t_lookup();
    for (int n = 0; n < 8; n++) wr(12'h200 + 12'(n * 64), 32'h0);
    wr(12'h280, 32'h0002_03eb);
    `CHK("pres", 8'h04, nodePresent)
    lk(40'h00_0200_00c0, 1'b1, 3'h2, 3'h1);
    lk(40'h00_0200_0080, 1'b0, 3'h0, 3'h0);
    lk(40'h00_0400_00c0, 1'b0, 3'h0, 3'h0);
    wr(12'h280, 32'h0002_020b);
    lk(40'h00_0400_00c0, 1'b1, 3'h2, 3'h1);
    for (int k = 0; k < 4; k++) begin
      wr(12'h280, 32'h0002_01e1 | 32'(k << 9));
      lk(40'h00_0200_03c0, 1'b1, 3'h2, 3'((1 << k) - 1));
    end
    wr(12'h280, 32'h0002_01f5);
    lk(40'h00_0200_0080, 1'b1, 3'h2, 3'h0);
    lk(40'h00_0200_00c0, 1'b0, 3'h0, 3'h0);
    wr(12'h280, 32'h0002_03ef);
    lk(40'h00_0200_00c0, 1'b0, 3'h0, 3'h0);
    wr(12'h280, 32'h0002_03ea);
    lk(40'h00_0200_00c0, 1'b0, 3'h0, 3'h0);
    $display("test lookup done");
  endtask

  // Main sequence
  initial begin
    arst_n = 1'b0;
    csrAddr = 12'h0;
    csrRd = 1'b0;
    csrWr = 1'b0;
    csrWrData = 32'h0;
    busResetCmd = 1'b0;
    lookupValid = 1'b0;
    lookupAddr = 40'h0;
    repeat (6) @(posedge clk);
    #1;
    arst_n = 1'b1;
    t_reset();
    t_cfg();
    t_node_reset_request();
    t_map();
    t_lookup();
    results();
  end
endmodule
`default_nettype wire
